/* File: logic/bus_handover_pkg.sv */
// Constants and types for the request/grant bus handover logic
// Overview of operation
// - Hand over bus only after current cycle
// - Two lines; first line wins over second
// - One-clock grant pulse, then hold acknowledge
// - Bus interface detached during hold acknowledge
// - Release pulse; retake bus, enter T4
// - Three pulses; idle clock between exchanges
// - Memory cycle: release at T4 if early
// - No release after low byte of word
// - No release after first interrupt acknowledge
// - Idle processor releases bus next clock
// - Starting cycle: request counts as early
package bus_handover_pkg;

    localparam int LINE_CNT  = 2;
    localparam int LINE_HIGH = 0;
    localparam int LINE_LOW  = 1;

    // Bus cycle state the core enters on the next clock
    typedef enum logic [5:0]
    {
        BS_TI = 6'h01,
        BS_T1 = 6'h02,
        BS_T2 = 6'h04,
        BS_T3 = 6'h08,
        BS_TW = 6'h10,
        BS_T4 = 6'h20
    } bus_state_t;

    typedef struct packed
    {
        bus_state_t state;
        logic       mem_cycle;
        logic       word_low;
        logic       inta_first;
        logic       lock_active;
        logic       cycle_starting;
    } core_status_t;

    typedef enum logic [5:0]
    {
        ARB_IDLE   = 6'h01,
        ARB_WAIT   = 6'h02,
        ARB_GRANT  = 6'h04,
        ARB_HOLD   = 6'h08,
        ARB_RETURN = 6'h10,
        ARB_GAP    = 6'h20
    } arb_state_t;

    localparam logic LINE_IDLE_LVL = 1'b1;
    localparam logic LINE_PULSE_LVL = 1'b0;

endpackage

/* File: logic/local_bus_request_grant.sv */
// Processor-side request/grant arbiter for the multiplexed local bus
`timescale 1ns/1ps

module local_bus_request_grant
(
    input  wire logic                           CLK,
    input  wire logic                           RST,
    input  wire bus_handover_pkg::core_status_t CORE_STAT,
    input  wire logic                           BUS_HANDOVER_LINE_HIGH_PRIO_IN,
    output logic                                BUS_HANDOVER_LINE_HIGH_PRIO_OUT,
    output logic                                BUS_HANDOVER_LINE_HIGH_PRIO_OE_N,
    input  wire logic                           BUS_HANDOVER_LINE_LOW_PRIO_IN,
    output logic                                BUS_HANDOVER_LINE_LOW_PRIO_OUT,
    output logic                                BUS_HANDOVER_LINE_LOW_PRIO_OE_N,
    output logic                                BUS_FLOAT,
    output logic                                RESUME_T4,
    output logic                                REQ_WAITING,
    output logic                                OWNER_LOW_PRIO
);

    bus_handover_pkg::arb_state_t state_q;
    bus_handover_pkg::arb_state_t state_d;

    logic [bus_handover_pkg::LINE_CNT-1:0] line_in;
    logic [bus_handover_pkg::LINE_CNT-1:0] line_low;
    logic [bus_handover_pkg::LINE_CNT-1:0] pend_q;
    logic [bus_handover_pkg::LINE_CNT-1:0] req_any;
    logic [bus_handover_pkg::LINE_CNT-1:0] oe_n_q;
    logic [bus_handover_pkg::LINE_CNT-1:0] out_q;
    logic                                  owner_q;
    logic                                  owner_d;
    logic                                  pick;
    logic                                  early_q;
    logic                                  early_now;
    logic                                  grant_ok;
    logic                                  exch_busy;
    logic                                  bus_float_q;
    logic                                  resume_q;
    logic                                  wait_q;

    // Line levels gathered into one vector for the per-line logic
    assign line_in[bus_handover_pkg::LINE_HIGH] = BUS_HANDOVER_LINE_HIGH_PRIO_IN;
    assign line_in[bus_handover_pkg::LINE_LOW]  = BUS_HANDOVER_LINE_LOW_PRIO_IN;

    // An exchange in progress owns its line until the idle gap is over
    assign exch_busy = (state_q != bus_handover_pkg::ARB_IDLE)
                    && (state_q != bus_handover_pkg::ARB_WAIT);

    genvar gi;
    generate
        for (gi = 0; gi < bus_handover_pkg::LINE_CNT; gi++)
        begin : g_line
            // Index of this line as a one-bit owner code
            localparam logic line_id = 1'(gi);

            // Own drive is never mistaken for a request
            assign line_low[gi] = (line_in[gi] == bus_handover_pkg::LINE_PULSE_LVL)
                               && oe_n_q[gi];
            assign req_any[gi] = pend_q[gi] | line_low[gi];

            // Request pulse is remembered until the arbiter takes it
            always_ff @(posedge CLK)
            begin
                if (RST)
                    pend_q[gi] <= 1'b0;
                // A request taken at once is not kept for a second exchange
                else if ((state_q == bus_handover_pkg::ARB_IDLE) && (pick == line_id))
                    pend_q[gi] <= 1'b0;
                else if (line_low[gi] && !(exch_busy && (owner_q == line_id)))
                    pend_q[gi] <= 1'b1;
            end

            // One-clock grant pulse on the line of the winner
            always_ff @(posedge CLK)
            begin
                if (RST)
                begin
                    oe_n_q[gi] <= 1'b1;
                    out_q[gi]  <= bus_handover_pkg::LINE_IDLE_LVL;
                end
                else if ((state_d == bus_handover_pkg::ARB_GRANT) && (owner_d == line_id))
                begin
                    oe_n_q[gi] <= 1'b0;
                    out_q[gi]  <= bus_handover_pkg::LINE_PULSE_LVL;
                end
                else
                begin
                    oe_n_q[gi] <= 1'b1;
                    out_q[gi]  <= bus_handover_pkg::LINE_IDLE_LVL;
                end
            end
        end
    endgenerate

    // First line wins when both ask together
    assign pick = req_any[bus_handover_pkg::LINE_HIGH] ? 1'b0 : 1'b1;

    // Request counts as early up to T2, or when no cycle has begun yet
    assign early_now = (CORE_STAT.state == bus_handover_pkg::BS_TI)
                    || (CORE_STAT.state == bus_handover_pkg::BS_T1)
                    || (CORE_STAT.state == bus_handover_pkg::BS_T2)
                    || CORE_STAT.cycle_starting;

    // Release points of the core's bus cycle
    always_comb
    begin
        grant_ok = 1'b0;
        if (CORE_STAT.lock_active)
            grant_ok = 1'b0;
        else if ((CORE_STAT.state == bus_handover_pkg::BS_TI) && !CORE_STAT.cycle_starting)
            grant_ok = 1'b1;
        else if (CORE_STAT.state == bus_handover_pkg::BS_T4)
            grant_ok = !CORE_STAT.inta_first
                    && (!CORE_STAT.mem_cycle
                        || (early_q && !CORE_STAT.word_low));
    end

    // Exchange sequence: wait for a release point, grant, hold, return, gap
    always_comb
    begin
        state_d = state_q;
        owner_d = owner_q;
        unique case (state_q)
            bus_handover_pkg::ARB_IDLE:
            begin
                if (|req_any)
                begin
                    state_d = bus_handover_pkg::ARB_WAIT;
                    owner_d = pick;
                end
            end
            bus_handover_pkg::ARB_WAIT:
            begin
                if (grant_ok)
                    state_d = bus_handover_pkg::ARB_GRANT;
            end
            bus_handover_pkg::ARB_GRANT:
                state_d = bus_handover_pkg::ARB_HOLD;
            bus_handover_pkg::ARB_HOLD:
            begin
                if (line_low[owner_q])
                    state_d = bus_handover_pkg::ARB_RETURN;
            end
            bus_handover_pkg::ARB_RETURN:
                state_d = bus_handover_pkg::ARB_GAP;
            bus_handover_pkg::ARB_GAP:
                state_d = bus_handover_pkg::ARB_IDLE;
            // A corrupted one-hot code falls back to idle
            default:
                state_d = bus_handover_pkg::ARB_IDLE;
        endcase
    end

    // Arbiter state and owner of the current exchange
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            state_q <= bus_handover_pkg::ARB_IDLE;
            owner_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            owner_q <= owner_d;
        end
    end

    // Early flag follows the cycle in which the request is pending
    always_ff @(posedge CLK)
    begin
        if (RST)
            early_q <= 1'b0;
        else if (state_q == bus_handover_pkg::ARB_IDLE)
            early_q <= early_now;
        else if (state_q == bus_handover_pkg::ARB_WAIT)
        begin
            if (CORE_STAT.state == bus_handover_pkg::BS_T4)
                early_q <= 1'b0;
            else if (early_now)
                early_q <= 1'b1;
        end
        else
            early_q <= 1'b0;
    end

    // Bus interface floats from the clock after the grant to the release
    always_ff @(posedge CLK)
    begin
        if (RST)
            bus_float_q <= 1'b0;
        else
            bus_float_q <= (state_d == bus_handover_pkg::ARB_HOLD);
    end

    // One-clock pulse that hands the bus back to the core in T4
    always_ff @(posedge CLK)
    begin
        if (RST)
            resume_q <= 1'b0;
        else
            resume_q <= (state_d == bus_handover_pkg::ARB_RETURN);
    end

    // Request accepted and still waiting for a release point
    always_ff @(posedge CLK)
    begin
        if (RST)
            wait_q <= 1'b0;
        else
            wait_q <= (state_d == bus_handover_pkg::ARB_WAIT);
    end

    assign BUS_HANDOVER_LINE_HIGH_PRIO_OUT  = out_q[bus_handover_pkg::LINE_HIGH];
    assign BUS_HANDOVER_LINE_HIGH_PRIO_OE_N = oe_n_q[bus_handover_pkg::LINE_HIGH];
    assign BUS_HANDOVER_LINE_LOW_PRIO_OUT   = out_q[bus_handover_pkg::LINE_LOW];
    assign BUS_HANDOVER_LINE_LOW_PRIO_OE_N  = oe_n_q[bus_handover_pkg::LINE_LOW];
    assign BUS_FLOAT                        = bus_float_q;
    assign RESUME_T4                        = resume_q;
    assign REQ_WAITING                      = wait_q;
    assign OWNER_LOW_PRIO                   = owner_q;

endmodule

/* File: tb/handover_props.sv */
// Checker for the request/grant handover arbiter
`timescale 1ns/1ps
module handover_props
(
    input wire logic                           CLK,
    input wire logic                           RST,
    input wire bus_handover_pkg::core_status_t CORE_STAT,
    input wire logic                           BUS_HANDOVER_LINE_HIGH_PRIO_OE_N,
    input wire logic                           BUS_HANDOVER_LINE_LOW_PRIO_OE_N,
    input wire logic                           BUS_FLOAT,
    input wire logic                           RESUME_T4
);
    wire g0  = BUS_HANDOVER_LINE_HIGH_PRIO_OE_N;
    wire g1  = BUS_HANDOVER_LINE_LOW_PRIO_OE_N;
    wire mid = |CORE_STAT.state[4:1];
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    sequence s_pulse;
        $fell(g0) ##1 $rose(g0);
    endsequence
    a_grant_one_clk: assert property ($fell(g0) |=> g0)
        else $error("grant pulse not one clock");
    a_grant_one_low: assert property ($fell(g1) |=> g1)
        else $error("low line grant pulse not one clock");
    a_grant_then_hold: assert property (s_pulse |-> BUS_FLOAT)
        else $error("no hold after grant");
    a_resume_ends_hold: assert property (RESUME_T4 |-> !BUS_FLOAT && $past(BUS_FLOAT))
        else $error("resume without hold");
    a_no_midcycle: assert property (mid |=> g0 && g1)
        else $error("grant inside bus cycle");
    a_no_grant_lock: assert property (CORE_STAT.lock_active |=> g0 && g1)
        else $error("grant while locked");
    a_no_word_low: assert property (CORE_STAT.mem_cycle && CORE_STAT.word_low |=> g0 && g1)
        else $error("grant after low byte");
    a_no_inta_first: assert property (CORE_STAT.inta_first |=> g0 && g1)
        else $error("grant after first acknowledge");
    a_single_grant: assert property (g0 || g1)
        else $error("both lines granted");
endmodule
bind local_bus_request_grant handover_props i_props
(
    .CLK                             (CLK),
    .RST                             (RST),
    .CORE_STAT                       (CORE_STAT),
    .BUS_HANDOVER_LINE_HIGH_PRIO_OE_N(BUS_HANDOVER_LINE_HIGH_PRIO_OE_N),
    .BUS_HANDOVER_LINE_LOW_PRIO_OE_N (BUS_HANDOVER_LINE_LOW_PRIO_OE_N),
    .BUS_FLOAT                       (BUS_FLOAT),
    .RESUME_T4                       (RESUME_T4)
);

/* File: tb/master_model.sv */
// Far-side master: pulses one request/grant line, pull-up when idle
`timescale 1ns/1ps
module master_model
(
    input  wire logic pulse,
    input  wire logic dut_out,
    input  wire logic dut_oe_n,
    output logic      line
);
    assign line = !dut_oe_n ? dut_out : !pulse;
endmodule

/* File: tb/tb.sv */
// Testbench for the request/grant handover arbiter
`timescale 1ns/1ps
module tb;
    logic                           CLK = 1'b0;
    logic                           RST = 1'b1;
    bus_handover_pkg::core_status_t cs;
    logic [1:0]                     pls = 2'h0;
    wire  [1:0]                     ln, oe_n, outv;
    wire                            flt, res, rw, own;
    int                             num_errors = 0;
    int                             total_checks = 0;
    always #12.5 CLK = ~CLK;
    local_bus_request_grant i_dut
    (
        .CLK(CLK), .RST(RST), .CORE_STAT(cs),
        .BUS_HANDOVER_LINE_HIGH_PRIO_IN  (ln[0]),
        .BUS_HANDOVER_LINE_HIGH_PRIO_OUT (outv[0]),
        .BUS_HANDOVER_LINE_HIGH_PRIO_OE_N(oe_n[0]),
        .BUS_HANDOVER_LINE_LOW_PRIO_IN   (ln[1]),
        .BUS_HANDOVER_LINE_LOW_PRIO_OUT  (outv[1]),
        .BUS_HANDOVER_LINE_LOW_PRIO_OE_N (oe_n[1]),
        .BUS_FLOAT(flt), .RESUME_T4(res), .REQ_WAITING(rw), .OWNER_LOW_PRIO(own)
    );
    master_model i_m0 (.pulse(pls[0]), .dut_out(outv[0]), .dut_oe_n(oe_n[0]), .line(ln[0]));
    master_model i_m1 (.pulse(pls[1]), .dut_out(outv[1]), .dut_oe_n(oe_n[1]), .line(ln[1]));
    task cyc;
        @(posedge CLK);
        #2;
    endtask
    task chk(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %0t: got %b", $time, got);
        end
    endtask
    task st(input logic [5:0] s, input logic m, input logic w, input logic i, input logic l);
        cs = '{bus_handover_pkg::bus_state_t'(s), m, w, i, l, 1'b0};
    endtask
    task pulse(input logic [1:0] v);
        pls = v;
        cyc;
        pls = 2'h0;
    endtask
    task hold_rel(input int l);
        cyc;
        chk(flt, 1'b1);
        chk(oe_n[l], 1'b1);
        cyc;
        chk(flt, 1'b1);
        pls[l] = 1'b1;
        cyc;
        pls[l] = 1'b0;
        chk(res, 1'b1);
        chk(flt, 1'b0);
        cyc;
        chk(res, 1'b0);
    endtask
    task t_idle;
        pulse(2'h1);
        chk(rw, 1'b1);
        cyc;
        chk(ln[0], 1'b0);
        chk(rw, 1'b0);
        hold_rel(0);
        cyc;
    endtask
    task t_prio;
        pulse(2'h3);
        cyc;
        chk(oe_n[0], 1'b0);
        chk(oe_n[1], 1'b1);
        chk(own, 1'b0);
        hold_rel(0);
        for (int k = 0; k < 6 && oe_n[1] !== 1'b0; k++) cyc;
        chk(oe_n[1], 1'b0);
        chk(ln[1], 1'b0);
        chk(own, 1'b1);
        hold_rel(1);
        cyc;
    endtask
    // Early or late request in a memory cycle; a late request, low byte or first acknowledge defers it
    task t_mem(input logic w, input logic i, input logic late);
        st(late ? 6'h08 : 6'h02, 1'b1, w, i, 1'b0);
        pulse(2'h1);
        if (!late)
        begin
            st(6'h04, 1'b1, w, i, 1'b0);
            cyc;
            st(6'h08, 1'b1, w, i, 1'b0);
            cyc;
            chk(oe_n[0], 1'b1);
        end
        st(6'h20, 1'b1, w, i, 1'b0);
        cyc;
        chk(oe_n[0], w | i | late);
        st(6'h01, 1'b0, 1'b0, 1'b0, 1'b0);
        if (w | i | late)
        begin
            cyc;
            chk(oe_n[0], 1'b0);
        end
        hold_rel(0);
        cyc;
    endtask
    task t_lock;
        st(6'h01, 1'b0, 1'b0, 1'b0, 1'b1);
        pulse(2'h1);
        repeat (3)
        begin
            cyc;
            chk(oe_n[0], 1'b1);
        end
        st(6'h01, 1'b0, 1'b0, 1'b0, 1'b0);
        cyc;
        chk(oe_n[0], 1'b0);
        hold_rel(0);
        cyc;
    endtask
    // Request while a memory cycle is about to start counts as early
    task t_start;
        cs = '{bus_handover_pkg::BS_TI, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
        pulse(2'h1);
        cyc;
        chk(oe_n[0], 1'b1);
        st(6'h08, 1'b1, 1'b0, 1'b0, 1'b0);
        cyc;
        chk(oe_n[0], 1'b1);
        st(6'h20, 1'b1, 1'b0, 1'b0, 1'b0);
        cyc;
        chk(oe_n[0], 1'b0);
        st(6'h01, 1'b0, 1'b0, 1'b0, 1'b0);
        hold_rel(0);
        cyc;
    endtask
    task stop_test;
        if (num_errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        st(6'h01, 1'b0, 1'b0, 1'b0, 1'b0);
        repeat (4) @(posedge CLK);
        #2 RST = 1'b0;
        t_idle;
        t_prio;
        t_mem(1'b0, 1'b0, 1'b0);
        t_mem(1'b1, 1'b0, 1'b0);
        t_mem(1'b0, 1'b1, 1'b0);
        t_mem(1'b0, 1'b0, 1'b1);
        t_lock;
        t_start;
        stop_test;
    end
    initial
    begin
        #20000;
        num_errors++;
        stop_test;
    end
endmodule
